/* plh_pkg.sv */
// constants and carrier types for the pll lock indicator and holdover control
// Function
// - lock pin select code 000100b enters current-source lock indication
// - current-source mode: source current while lock true, ground while false
// - comparator selectable high or low on reference monitor and status pins
// - holdover acts only with both enable bits set, else never high impedance
// - manual mode: align strobe falling edge enters high impedance, edge detected
// - manual exit only at next reference pfd edge after strobe is high
// - exit from high impedance resets b counter, prescaler left running
// - automatic mode: sensed lock pin low enters high impedance
// - comparator enable clear makes holdover sense lock pin as high
// - external holdover bit: clear automatic, set manual via strobe
// - automatic holdover holds high impedance while no reference edge arrives
// - after automatic exit, re-entry blocked until lock pin senses high again or manual mode is set
// - holdover tracks selected reference, ends at its next pfd edge
// - lock counter field sets consecutive cycles, code 00b is five
// - digital lock disable bit must be zero for lock circuit to run
// - window bit clear selects high range window
// - reference select: auto switch, preference, buffer enable field
// - lock after n in-window cycles, unlock on one cycle beyond unlock window
package plh_pkg;
  // ==========================================================
  // register offsets
  localparam logic [7:0] STATUS_PIN_SEL_OFS = 8'h17;
  localparam logic [7:0] LOCK_DETECT_CFG_OFS = 8'h18;
  localparam logic [7:0] LOCK_PIN_SEL_OFS = 8'h1A;
  localparam logic [7:0] REFERENCE_MONITOR_PIN_PIN_SEL_OFS = 8'h1B;
  localparam logic [7:0] REF_SEL_CTRL_OFS = 8'h1C;
  localparam logic [7:0] HOLDOVER_CTRL_OFS = 8'h1D;
  localparam logic [7:0] CHARGE_THRESH_OFS = 8'h1E;
  localparam logic [7:0] BLOCK_STATUS_OFS = 8'h21;
  // ==========================================================
  // field positions
  localparam int LD_CNT_LSB = 5;
  localparam int LD_WINDOW_BIT = 4;
  localparam int LD_DISABLE_BIT = 3;
  localparam int STATUS_SEL_LSB = 2;
  localparam int REF_AUTO_BIT = 4;
  localparam int REF_PREFER_BIT = 3;
  localparam int REF_BUF_LSB = 1;
  localparam int HO_EN0_BIT = 0;
  localparam int HO_EXT_BIT = 1;
  localparam int HO_EN2_BIT = 2;
  localparam int HO_CMP_EN_BIT = 3;
  // ==========================================================
  // codes and reset values
  localparam logic [5:0] LOCK_PIN_CUR_SRC = 6'h04;
  localparam logic [4:0] REFERENCE_MONITOR_PIN_CMP_HI = 5'h0E;
  localparam logic [4:0] REFERENCE_MONITOR_PIN_CMP_LO = 5'h0F;
  localparam logic [5:0] STATUS_CMP_HI = 6'h2E;
  localparam logic [5:0] STATUS_CMP_LO = 6'h2F;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [7:0] CHARGE_THRESH_RST = 8'h20;
  // lock counts per counter code 00b..11b
  localparam logic [7:0] LOCK_CNT_C0 = 8'h05;
  localparam logic [7:0] LOCK_CNT_C1 = 8'h10;
  localparam logic [7:0] LOCK_CNT_C2 = 8'h40;
  localparam logic [7:0] LOCK_CNT_C3 = 8'hFF;

  typedef enum logic [1:0] {
    HO_IDLE = 2'b00,
    HO_HIZ = 2'b01,
    HO_REARM = 2'b10
  } plh_ho_state_e;

  // one pfd comparison, pulsed once per pfd cycle
  typedef struct packed {
    logic cycle;
    logic in_lock_hi;
    logic in_lock_lo;
    logic over_unlock_hi;
    logic over_unlock_lo;
  } plh_pfd_s;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } plh_bus_s;
endpackage : plh_pkg

/* plh_top.sv */
// lock indicator, lock pin comparator and holdover control
`timescale 1ns/1ps
`default_nettype none
module plh_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire plh_pkg::plh_bus_s bus,
  output logic [7:0] rd_data_ff,
  input wire plh_pkg::plh_pfd_s phase_frequency_detector,
  input wire logic ref_pfd_edge,
  input wire logic align_strobe_n,
  output logic dld_ff,
  output logic lock_pin_src_ff,
  output logic lock_pin_gnd_ff,
  output logic reference_monitor_pin_pin_ff,
  output logic status_pin_ff,
  output logic cp_hiz_ff,
  output logic b_cnt_reset_ff,
  output logic ref_auto_switch_ff,
  output logic ref_prefer_second_ff,
  output logic [1:0] ref_buf_en_ff
);
  // ==========================================================
  // registers
  logic [7:0] status_sel_ff, ld_cfg_ff, lock_sel_ff, reference_monitor_pin_sel_ff;
  logic [7:0] ref_ctrl_ff, ho_ctrl_ff, thresh_ff;
  logic [7:0] lock_cnt_ff, charge_cnt_ff;
  logic cmp_ff, strobe_d_ff;
  plh_pkg::plh_ho_state_e ho_state_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_sel_ff <= plh_pkg::REG_RST;
      ld_cfg_ff <= plh_pkg::REG_RST;
      lock_sel_ff <= plh_pkg::REG_RST;
      reference_monitor_pin_sel_ff <= plh_pkg::REG_RST;
      ref_ctrl_ff <= plh_pkg::REG_RST;
      ho_ctrl_ff <= plh_pkg::REG_RST;
      thresh_ff <= plh_pkg::CHARGE_THRESH_RST;
    end else if (bus.wr) begin
      case (bus.addr)
        plh_pkg::STATUS_PIN_SEL_OFS: status_sel_ff <= bus.wdata;
        plh_pkg::LOCK_DETECT_CFG_OFS: ld_cfg_ff <= bus.wdata;
        plh_pkg::LOCK_PIN_SEL_OFS: lock_sel_ff <= {2'h0, bus.wdata[5:0]};
        plh_pkg::REFERENCE_MONITOR_PIN_PIN_SEL_OFS: reference_monitor_pin_sel_ff <= {3'h0, bus.wdata[4:0]};
        plh_pkg::REF_SEL_CTRL_OFS: ref_ctrl_ff <= bus.wdata;
        plh_pkg::HOLDOVER_CTRL_OFS: ho_ctrl_ff <= {4'h0, bus.wdata[3:0]};
        plh_pkg::CHARGE_THRESH_OFS: thresh_ff <= bus.wdata;
        default: ;
      endcase
    end
  end

  // unmapped addresses read as zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_ff <= 8'h00;
    end else if (bus.rd) begin
      case (bus.addr)
        plh_pkg::STATUS_PIN_SEL_OFS: rd_data_ff <= status_sel_ff;
        plh_pkg::LOCK_DETECT_CFG_OFS: rd_data_ff <= ld_cfg_ff;
        plh_pkg::LOCK_PIN_SEL_OFS: rd_data_ff <= lock_sel_ff;
        plh_pkg::REFERENCE_MONITOR_PIN_PIN_SEL_OFS: rd_data_ff <= reference_monitor_pin_sel_ff;
        plh_pkg::REF_SEL_CTRL_OFS: rd_data_ff <= ref_ctrl_ff;
        plh_pkg::HOLDOVER_CTRL_OFS: rd_data_ff <= ho_ctrl_ff;
        plh_pkg::CHARGE_THRESH_OFS: rd_data_ff <= thresh_ff;
        plh_pkg::BLOCK_STATUS_OFS: begin
          rd_data_ff <= {2'h0, ho_state_ff, cp_hiz_ff, cmp_ff, lock_pin_src_ff, dld_ff};
        end
        default: rd_data_ff <= 8'h00;
      endcase
    end else begin
      rd_data_ff <= 8'h00;
    end
  end

  // ==========================================================
  // reference select
  // reference select controls
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_auto_switch_ff <= 1'b0;
      ref_prefer_second_ff <= 1'b0;
      ref_buf_en_ff <= 2'b00;
    end else begin
      ref_auto_switch_ff <= ref_ctrl_ff[plh_pkg::REF_AUTO_BIT];
      ref_prefer_second_ff <= ref_ctrl_ff[plh_pkg::REF_PREFER_BIT];
      ref_buf_en_ff <= ref_ctrl_ff[plh_pkg::REF_BUF_LSB +: 2];
    end
  end

  // ==========================================================
  // digital lock indicator
  logic ld_disabled, in_lock, over_unlock, lock_hit;
  logic [7:0] lock_target;
  assign ld_disabled = ld_cfg_ff[plh_pkg::LD_DISABLE_BIT];
  assign in_lock = ld_cfg_ff[plh_pkg::LD_WINDOW_BIT] ? phase_frequency_detector.in_lock_lo : phase_frequency_detector.in_lock_hi;
  assign over_unlock = ld_cfg_ff[plh_pkg::LD_WINDOW_BIT] ? phase_frequency_detector.over_unlock_lo
                                                          : phase_frequency_detector.over_unlock_hi;
  always_comb begin
    case (ld_cfg_ff[plh_pkg::LD_CNT_LSB +: 2])
      2'b00: lock_target = plh_pkg::LOCK_CNT_C0;
      2'b01: lock_target = plh_pkg::LOCK_CNT_C1;
      2'b10: lock_target = plh_pkg::LOCK_CNT_C2;
      default: lock_target = plh_pkg::LOCK_CNT_C3;
    endcase
  end
  // nine bits so a saturated run count still reaches the top code
  assign lock_hit = phase_frequency_detector.cycle && in_lock
                    && (({1'b0, lock_cnt_ff} + 9'h001) >= {1'b0, lock_target});

  // disable bit stops the lock circuit
  // n good cycles lock, one bad cycle unlocks
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lock_cnt_ff <= 8'h00;
      dld_ff <= 1'b0;
    end else if (ld_disabled) begin
      lock_cnt_ff <= 8'h00;
      dld_ff <= 1'b0;
    end else if (phase_frequency_detector.cycle) begin
      if (!in_lock) begin
        lock_cnt_ff <= 8'h00;
      end else if (lock_cnt_ff != 8'hFF) begin
        lock_cnt_ff <= lock_cnt_ff + 8'h01;
      end
      if (dld_ff && over_unlock) begin
        dld_ff <= 1'b0;
      end else if (!dld_ff && lock_hit) begin
        dld_ff <= 1'b1;
      end
    end
  end

  // ==========================================================
  // lock pin drive and comparator
  logic cur_src_mode, pin_level;
  assign cur_src_mode = lock_sel_ff[5:0] == plh_pkg::LOCK_PIN_CUR_SRC;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lock_pin_src_ff <= 1'b0;
      lock_pin_gnd_ff <= 1'b0;
    end else begin
      lock_pin_src_ff <= cur_src_mode && dld_ff;
      lock_pin_gnd_ff <= cur_src_mode && !dld_ff;
    end
  end

  // charge modelled as a run counter
  // any false cycle discharges at once
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      charge_cnt_ff <= 8'h00;
    end else if (!lock_pin_src_ff) begin
      charge_cnt_ff <= 8'h00;
    end else if (phase_frequency_detector.cycle && charge_cnt_ff != 8'hFF) begin
      charge_cnt_ff <= charge_cnt_ff + 8'h01;
    end
  end
  // other pin modes drive the lock indicator level straight out
  assign pin_level = cur_src_mode ? (charge_cnt_ff >= thresh_ff) : dld_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmp_ff <= 1'b0;
    end else begin
      cmp_ff <= pin_level;
    end
  end

  // comparator on monitor pins, both polarities
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reference_monitor_pin_pin_ff <= 1'b0;
      status_pin_ff <= 1'b0;
    end else begin
      reference_monitor_pin_pin_ff <= (reference_monitor_pin_sel_ff[4:0] == plh_pkg::REFERENCE_MONITOR_PIN_CMP_HI) ? cmp_ff :
                       (reference_monitor_pin_sel_ff[4:0] == plh_pkg::REFERENCE_MONITOR_PIN_CMP_LO) ? !cmp_ff : 1'b0;
      status_pin_ff <= (status_sel_ff[7:2] == plh_pkg::STATUS_CMP_HI) ? cmp_ff :
                       (status_sel_ff[7:2] == plh_pkg::STATUS_CMP_LO) ? !cmp_ff : 1'b0;
    end
  end

  // ==========================================================
  // holdover
  logic ho_en, ho_manual, sensed_high, strobe_fall, enter, leave;
  assign ho_en = ho_ctrl_ff[plh_pkg::HO_EN0_BIT] && ho_ctrl_ff[plh_pkg::HO_EN2_BIT];
  assign ho_manual = ho_ctrl_ff[plh_pkg::HO_EXT_BIT];
  assign sensed_high = !ho_ctrl_ff[plh_pkg::HO_CMP_EN_BIT] || cmp_ff;
  assign strobe_fall = strobe_d_ff && !align_strobe_n;
  assign enter = ho_manual ? strobe_fall : !sensed_high;
  // exit waits for the selected reference pfd edge
  assign leave = ref_pfd_edge && (!ho_manual || align_strobe_n);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strobe_d_ff <= 1'b1;
    end else begin
      strobe_d_ff <= align_strobe_n;
    end
  end

  // b counter reset with exit; prescaler has no reset here
  // re-arm once the pin senses high or the external holdover bit is set
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ho_state_ff <= plh_pkg::HO_IDLE;
      cp_hiz_ff <= 1'b0;
      b_cnt_reset_ff <= 1'b0;
    end else begin
      b_cnt_reset_ff <= 1'b0;
      if (!ho_en) begin
        ho_state_ff <= plh_pkg::HO_IDLE;
        cp_hiz_ff <= 1'b0;
      end else begin
        case (ho_state_ff)
          plh_pkg::HO_IDLE: begin
            if (enter) begin
              ho_state_ff <= plh_pkg::HO_HIZ;
              cp_hiz_ff <= 1'b1;
            end
          end
          plh_pkg::HO_HIZ: begin
            if (leave) begin
              ho_state_ff <= ho_manual ? plh_pkg::HO_IDLE : plh_pkg::HO_REARM;
              cp_hiz_ff <= 1'b0;
              b_cnt_reset_ff <= 1'b1;
            end
          end
          plh_pkg::HO_REARM: begin
            if (ho_manual || sensed_high) begin
              ho_state_ff <= plh_pkg::HO_IDLE;
            end
          end
          default: begin
            ho_state_ff <= plh_pkg::HO_IDLE;
            cp_hiz_ff <= 1'b0;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_hiz_needs_enable: assert property (cp_hiz_ff |-> $past(ho_en))
    else $error("high impedance without holdover enabled");
  chk_manual_entry: assert property (
    ho_en && ho_manual && strobe_fall && ho_state_ff == plh_pkg::HO_IDLE |=> cp_hiz_ff)
    else $error("strobe fall did not enter holdover");
  chk_exit_on_edge: assert property (cp_hiz_ff && !$past(cp_hiz_ff, 1) ##0
    !(ref_pfd_edge) [*2] |-> cp_hiz_ff || !$past(ho_en))
    else $error("left holdover without reference edge");
  chk_bcnt_with_exit: assert property ($fell(cp_hiz_ff) && $past(ho_en) |-> b_cnt_reset_ff)
    else $error("b counter reset missing on exit");
  chk_auto_entry: assert property (ho_en && !ho_manual && !sensed_high
    && ho_state_ff == plh_pkg::HO_IDLE |=> cp_hiz_ff)
    else $error("lock loss did not enter holdover");
  chk_rearm_block: assert property (ho_state_ff == plh_pkg::HO_REARM && !sensed_high
    && ho_en && !ho_manual |=> !cp_hiz_ff)
    else $error("holdover re-entered before lock pin high");
  chk_lock_disable: assert property (ld_disabled |=> !dld_ff)
    else $error("lock indicator set while disabled");
  chk_unlock_one: assert property (dld_ff && phase_frequency_detector.cycle && over_unlock && !ld_disabled
    |=> !dld_ff)
    else $error("lock indicator kept after unlock cycle");
  chk_src_gnd: assert property (lock_pin_src_ff |-> !lock_pin_gnd_ff && $past(dld_ff))
    else $error("lock pin drive conflicts with indicator");
  chk_gnd_follow: assert property (lock_pin_gnd_ff |-> $past(cur_src_mode) && !$past(dld_ff))
    else $error("lock pin grounded while locked");
  chk_cur_src_sel: assert property (cur_src_mode && dld_ff |=> lock_pin_src_ff)
    else $error("current source not on in lock pin source mode");
  chk_cmp_low_route: assert property (reference_monitor_pin_sel_ff[4:0] == plh_pkg::REFERENCE_MONITOR_PIN_CMP_LO
    && $stable(reference_monitor_pin_sel_ff) |=> reference_monitor_pin_pin_ff == !$past(cmp_ff))
    else $error("inverted comparator not on monitor pin");
  chk_cmp_high_route: assert property (reference_monitor_pin_sel_ff[4:0] == plh_pkg::REFERENCE_MONITOR_PIN_CMP_HI
    |=> reference_monitor_pin_pin_ff == $past(cmp_ff))
    else $error("comparator not on monitor pin");
  chk_status_route: assert property (status_sel_ff[7:2] == plh_pkg::STATUS_CMP_LO
    |=> status_pin_ff == !$past(cmp_ff))
    else $error("inverted comparator not on status pin");
  chk_manual_no_level: assert property (ho_en && ho_manual && !strobe_fall
    && ho_state_ff == plh_pkg::HO_IDLE |=> !cp_hiz_ff)
    else $error("manual holdover entered without strobe edge");
  chk_manual_hold: assert property (ho_en && ho_manual && cp_hiz_ff && !align_strobe_n
    |=> cp_hiz_ff)
    else $error("manual holdover left while strobe low");
  chk_bcnt_pulse: assert property (b_cnt_reset_ff |=> !b_cnt_reset_ff)
    else $error("b counter reset longer than one cycle");
  chk_no_ref_hold: assert property (ho_en && cp_hiz_ff && !ref_pfd_edge |=> cp_hiz_ff)
    else $error("holdover left without reference edge");
  chk_cmp_off_sense: assert property (ho_en && !ho_manual
    && !ho_ctrl_ff[plh_pkg::HO_CMP_EN_BIT] && ho_state_ff == plh_pkg::HO_IDLE
    |=> !cp_hiz_ff)
    else $error("holdover entered with comparator disabled");

  cov_manual_cycle: cover property (strobe_fall ##[1:50] b_cnt_reset_ff);
  cov_auto_cycle: cover property (ho_state_ff == plh_pkg::HO_REARM ##[1:300]
    ho_state_ff == plh_pkg::HO_IDLE);
  cov_lock_gained: cover property ($rose(dld_ff));
  cov_pin_charged: cover property (cur_src_mode && $rose(cmp_ff));
  cov_auto_entry: cover property (!ho_manual && $rose(cp_hiz_ff));
endmodule : plh_top
`default_nettype wire

/* plh_far_model.sv */
// far side model: selected reference pfd events and align strobe driver
`timescale 1ns/1ps
`default_nettype none
module plh_far_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ref_on,
  input wire logic good,
  input wire logic sync_req,
  output plh_pkg::plh_pfd_s pfd_ff,
  output logic ref_edge_ff,
  output logic strobe_n_ff
);
  logic [1:0] cnt_ff;
  // ==========================================================
  // reference events
  // one comparison per reference edge; a lost reference gives no events at all
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= 2'h0;
      pfd_ff <= '0;
      ref_edge_ff <= 1'h0;
    end else begin
      cnt_ff <= cnt_ff + 2'h1;
      pfd_ff <= '0;
      ref_edge_ff <= 1'h0;
      if (ref_on && cnt_ff == 2'h3) begin
        pfd_ff <= '{cycle: 1'h1, in_lock_hi: good, in_lock_lo: 1'h0,
                    over_unlock_hi: !good, over_unlock_lo: 1'h0};
        ref_edge_ff <= 1'h1;
      end
    end
  end
  // ==========================================================
  // align strobe
  // strobe used for holdover only, no divider sync
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strobe_n_ff <= 1'h1;
    end else begin
      strobe_n_ff <= !sync_req;
    end
  end
endmodule : plh_far_model
`default_nettype wire

/* tb.sv */
// self-checking testbench for the lock indicator and holdover control
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk;
  logic rst_n;
  plh_pkg::plh_bus_s bus;
  plh_pkg::plh_pfd_s phase_frequency_detector;
  logic [7:0] rd_data;
  logic [7:0] v;
  logic [7:0] d;
  logic ref_edge, strobe_n, digital_lock_indicator, src, gnd, reference_monitor_pin, status, cp_hiz, b_rst, r_auto, r_pref;
  logic [1:0] r_buf;
  logic ref_on, good, sync_req;
  logic [31:0] seed;
  int n_fail;
  int n_checks;
  logic [7:0] ofs [7] = '{8'h17, 8'h18, 8'h1A, 8'h1B, 8'h1C, 8'h1D, 8'h1E};
  logic [7:0] msk [7] = '{8'hFF, 8'hFF, 8'h3F, 8'h1F, 8'hFF, 8'h0F, 8'hFF};
  logic [7:0] rst_v [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h20};

  plh_top dut (.clk(clk), .rst_n(rst_n), .bus(bus), .rd_data_ff(rd_data), .phase_frequency_detector(phase_frequency_detector),
    .ref_pfd_edge(ref_edge), .align_strobe_n(strobe_n), .dld_ff(digital_lock_indicator),
    .lock_pin_src_ff(src), .lock_pin_gnd_ff(gnd), .reference_monitor_pin_pin_ff(reference_monitor_pin),
    .status_pin_ff(status), .cp_hiz_ff(cp_hiz), .b_cnt_reset_ff(b_rst),
    .ref_auto_switch_ff(r_auto), .ref_prefer_second_ff(r_pref), .ref_buf_en_ff(r_buf));
  plh_far_model far (.clk(clk), .rst_n(rst_n), .ref_on(ref_on), .good(good),
    .sync_req(sync_req), .pfd_ff(phase_frequency_detector), .ref_edge_ff(ref_edge), .strobe_n_ff(strobe_n));

  always #12.5 clk = ~clk;
  // ==========================================================
  // helpers
  function automatic logic [7:0] next_rand();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction : next_rand
  function automatic logic [7:0] exp_reg(input int i, input logic [7:0] x);
    return x & msk[i];
  endfunction : exp_reg
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] x);
    @(posedge clk);
    bus <= '{addr: a, wdata: x, wr: 1'h1, rd: 1'h0};
    @(posedge clk);
    bus <= '0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] x);
    @(posedge clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'h0, rd: 1'h1};
    @(posedge clk);
    bus <= '0;
    #1;
    x = rd_data;
  endtask : rd
  task automatic at(input int n);
    repeat (n) @(posedge clk);
  endtask : at
  // pfd events stop only when the reference is lost; the watchdog cuts that short
  task automatic wait_pfd(input int n);
    repeat (n) @(posedge clk iff phase_frequency_detector.cycle);
  endtask : wait_pfd
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_of_test
  // ==========================================================
  // watchdog
  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    $display("unexpected at %0t: timeout", $time);
    end_of_test();
  end
  // ==========================================================
  // main sequence
  initial begin
    clk = 1'h0;
    rst_n = 1'h0;
    bus = '0;
    ref_on = 1'h0;
    good = 1'h0;
    sync_req = 1'h0;
    seed = 32'h45;
    n_fail = 0;
    n_checks = 0;
    at(5);
    rst_n <= 1'h1;
    for (int i = 0; i < 7; i++) begin
      rd(ofs[i], v);
      chk(v, rst_v[i]);
      d = next_rand();
      wr(ofs[i], d);
      rd(ofs[i], v);
      chk(v, exp_reg(i, d));
      wr(ofs[i], rst_v[i]);
    end
    wr(8'h40, d);
    rd(8'h40, v);
    chk(v, 8'h00);
    for (int k = 0; k < 2; k++) begin
      d = (k == 0) ? 8'h16 : next_rand();
      wr(8'h1C, d);
      at(2);
      #1 chk({4'h0, r_auto, r_pref, r_buf}, {4'h0, d[4:1]});
    end
    $display("done: registers");
    wr(8'h18, 8'h10);
    at(1);
    ref_on <= 1'h1;
    good <= 1'h1;
    wait_pfd(8);
    at(2);
    #1 chk(digital_lock_indicator, 1'h0);
    wr(8'h18, 8'h00);
    wait_pfd(4);
    at(2);
    #1 chk(digital_lock_indicator, 1'h0);
    wait_pfd(1);
    at(2);
    #1 chk(digital_lock_indicator, 1'h1);
    at(1);
    good <= 1'h0;
    // the next event may already carry the old quality; the second one is bad
    wait_pfd(2);
    at(2);
    #1 chk(digital_lock_indicator, 1'h0);
    $display("done: lock");
    at(1);
    good <= 1'h1;
    sync_req <= 1'h1;
    at(6);
    #1 chk(cp_hiz, 1'h0);
    wr(8'h1D, 8'h07);
    at(6);
    #1 chk(cp_hiz, 1'h0);
    at(1);
    sync_req <= 1'h0;
    at(3);
    sync_req <= 1'h1;
    at(4);
    #1 chk(cp_hiz, 1'h1);
    at(1);
    ref_on <= 1'h0;
    at(2);
    sync_req <= 1'h0;
    at(12);
    #1 chk(cp_hiz, 1'h1);
    at(1);
    ref_on <= 1'h1;
    @(posedge clk iff ref_edge);
    #1 chk({cp_hiz, b_rst}, 2'h1);
    at(1);
    #1 chk(b_rst, 1'h0);
    $display("done: manual holdover");
    wr(8'h1D, 8'h00);
    wr(8'h1A, 8'h04);
    wait_pfd(45);
    at(2);
    #1 chk({src, gnd}, 2'h2);
    for (int k = 0; k < 2; k++) begin
      wr(8'h1B, k ? 8'h0F : 8'h0E);
      wr(8'h17, k ? 8'hBC : 8'hB8);
      at(3);
      #1 chk({reference_monitor_pin, status}, k ? 2'h0 : 2'h3);
    end
    wr(8'h18, 8'h08);
    at(1);
    #1 chk(digital_lock_indicator, 1'h0);
    wr(8'h18, 8'h00);
    wait_pfd(45);
    wr(8'h1D, 8'h0D);
    at(6);
    #1 chk(cp_hiz, 1'h0);
    at(1);
    good <= 1'h0;
    wait_pfd(2);
    ref_on <= 1'h0;
    at(8);
    #1 chk({cp_hiz, gnd, reference_monitor_pin}, 3'h7);
    at(20);
    #1 chk(cp_hiz, 1'h1);
    at(1);
    ref_on <= 1'h1;
    @(posedge clk iff ref_edge);
    #1 chk({cp_hiz, b_rst}, 2'h1);
    at(20);
    #1 chk(cp_hiz, 1'h0);
    rd(8'h21, v);
    chk(v, 8'h20);
    wr(8'h1D, 8'h00);
    wr(8'h1D, 8'h05);
    at(10);
    #1 chk(cp_hiz, 1'h0);
    wr(8'h1D, 8'h00);
    $display("done: automatic holdover");
    end_of_test();
  end
endmodule : tb
`default_nettype wire
